// >>> core/pbh_cfg.svh
// constants of the processor bus handshake interface
`ifndef PBH_CFG_SVH
`define PBH_CFG_SVH

`define PBH_CLK_MHZ    20
`define PBH_PHASE_NS   100
`define PBH_PHASE_CYC  ((`PBH_PHASE_NS * `PBH_CLK_MHZ + 999) / 1000)
`define PBH_PH_ONE     2'h0
`define PBH_PH_TWO     2'h1
`define PBH_PH_THREE   2'h2
`define PBH_PH_FOUR    2'h3
`define PBH_DAL_W      16
`define PBH_REG_W      4
`define PBH_BYTE_W     8

`endif

// >>> core/pbh_pkg.sv
// types of the processor bus handshake interface
package pbh_pkg;

	typedef enum logic [2:0] {
		PBH_OP_READ        = 3'h0,
		PBH_OP_READ_ACK    = 3'h1,
		PBH_OP_WRITE       = 3'h3,
		PBH_OP_WRITE_ACK   = 3'h2,
		PBH_OP_INPUT_WORD  = 3'h6,
		PBH_OP_OUTPUT_WORD = 3'h7
	} pbh_op_type;

endpackage

// >>> core/pbh_bridge.sv
// processor bus handshake interface: sequencer, phase clock and bus strobes
`timescale 1ns/1ns
`include "pbh_cfg.svh"

// Functional notes
// - sync request rises at phase two start
// - bus sync only via phase-three-end flip-flop
// - bus sync held until reply withdrawn
// - acknowledge request resets the sync flip-flop
// - write byte registered to bus at phase one start, address microcycle only
// - input request at phase two drives strobe
// - output request rises at phase one start
// - output strobe flip-flop clocked at phase three
// - output strobe sets only with reply reset
// - output strobe dropped when reply flop sets
// - no output strobe without sync request
// - bus reply sampled at phase one
// - reply forwarded only while bus sync active
// - read waits while reply or busy
// - input word waits for reply at phase three
// - low byte, then high byte to register with bit 0 inverted
// - requests drop at end of next phase one
// - reply set locks sync flip-flop set
// - read or write group waits on busy
// - reply reset at phase one releases sync
// - output completes on reply at phase three
module pbh_bridge #(
	parameter int DAL_W   = `PBH_DAL_W,
	parameter int REG_W   = `PBH_REG_W,
	parameter int PH_CYC  = `PBH_PHASE_CYC
) (
	input  wire logic                 CLK,
	input  wire logic                 RSTN,
	input  wire logic                 OP_VALID,
	input  wire pbh_pkg::pbh_op_type  OP_CODE,
	input  wire logic                 OP_BYTE,
	input  wire logic [DAL_W-1:0]     OP_ADDR,
	input  wire logic [DAL_W-1:0]     OP_WDATA,
	input  wire logic [REG_W-1:0]     OP_AREG,
	output logic                      OP_READY,
	output logic                      OP_DONE,
	output logic                      STORE_STB,
	output logic [REG_W-1:0]          STORE_REG,
	output logic [`PBH_BYTE_W-1:0]    STORE_DATA,
	output logic                      REPLY_OUT,
	output logic                      BUSY_OUT,
	output logic                      BUS_SYNC_N,
	output logic                      BUS_WRITE_BYTE_N,
	output logic                      BUS_INPUT_STROBE_N,
	output logic                      BUS_OUTPUT_STROBE_N,
	input  wire logic                 BUS_REPLY_N,
	input  wire logic [DAL_W-1:0]     DAL_I,
	output logic [DAL_W-1:0]          DAL_O,
	output logic                      DAL_OE
);

	// ****************************************
	// reset release
	// ****************************************
	logic rst_s1_q;
	logic rst_n_q;
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			rst_s1_q <= 1'b0;
			rst_n_q  <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n_q  <= rst_s1_q;
		end
	end
	// ****************************************
	// four-phase microcycle clock
	// ****************************************
	localparam logic [7:0] PH_LAST = 8'(PH_CYC - 1);
	logic [7:0] ph_cnt_q;
	logic [1:0] ph_idx_q;
	logic       end_ph1;
	logic       end_ph2;
	logic       end_ph3;
	logic       end_ph4;
	function automatic logic ph_end(input logic [1:0] idx, input logic [1:0] which,
		input logic [7:0] cnt);
		ph_end = (idx == which) && (cnt == PH_LAST);
	endfunction
	always_ff @(posedge CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			ph_cnt_q <= 8'h00;
			ph_idx_q <= `PBH_PH_ONE;
		end else if (ph_cnt_q == PH_LAST) begin
			ph_cnt_q <= 8'h00;
			ph_idx_q <= ph_idx_q + 2'h1;
		end else begin
			ph_cnt_q <= ph_cnt_q + 8'h01;
		end
	end
	assign end_ph1 = ph_end(ph_idx_q, `PBH_PH_ONE, ph_cnt_q);
	assign end_ph2 = ph_end(ph_idx_q, `PBH_PH_TWO, ph_cnt_q);
	assign end_ph3 = ph_end(ph_idx_q, `PBH_PH_THREE, ph_cnt_q);
	assign end_ph4 = ph_end(ph_idx_q, `PBH_PH_FOUR, ph_cnt_q);
	// ****************************************
	// interface flip-flops
	// ****************************************
	logic reply_ff_q;
	logic sync_ff_q;
	logic dout_ff_q;
	logic sync_req_q;
	logic iack_req_q;
	logic in_req_q;
	logic out_req_q;
	logic rd_xfer_q;
	logic reply_in;
	logic busy;
	always_ff @(posedge CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			reply_ff_q <= 1'b0;
		end else if (end_ph4) begin
			reply_ff_q <= !BUS_REPLY_N;
		end
	end
	always_ff @(posedge CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			sync_ff_q  <= 1'b0;
			BUS_SYNC_N <= 1'b1;
		end else if (end_ph3) begin
			if (iack_req_q) begin
				sync_ff_q  <= 1'b0;
				BUS_SYNC_N <= 1'b1;
			end else if (reply_ff_q && sync_ff_q) begin
				sync_ff_q  <= 1'b1;
				BUS_SYNC_N <= 1'b0;
			end else begin
				sync_ff_q  <= sync_req_q;
				BUS_SYNC_N <= !sync_req_q;
			end
		end
	end
	always_ff @(posedge CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			dout_ff_q           <= 1'b0;
			BUS_OUTPUT_STROBE_N <= 1'b1;
		end else if ((end_ph4 && !BUS_REPLY_N) || reply_ff_q || !out_req_q) begin
			dout_ff_q           <= 1'b0;
			BUS_OUTPUT_STROBE_N <= 1'b1;
		end else if (end_ph2 && !reply_ff_q && sync_req_q) begin
			dout_ff_q           <= 1'b1;
			BUS_OUTPUT_STROBE_N <= 1'b0;
		end
	end
	// reply to the sequencer needs bus sync, and input request on reads
	assign reply_in = reply_ff_q && sync_ff_q && (!rd_xfer_q || in_req_q);
	assign busy     = reply_ff_q;
	always_ff @(posedge CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			REPLY_OUT <= 1'b0;
			BUSY_OUT  <= 1'b0;
		end else begin
			REPLY_OUT <= reply_in;
			BUSY_OUT  <= busy;
		end
	end
	// ****************************************
	// microinstruction sequencer
	// ****************************************
	pbh_pkg::pbh_op_type op_q;
	logic                 byte_q;
	logic [DAL_W-1:0]     addr_q;
	logic [DAL_W-1:0]     wdata_q;
	logic [REG_W-1:0]     areg_q;
	logic                 hi_q;
	logic                 addr_next_q;
	logic                 addr_cyc_q;
	logic                 next_rd_q;
	logic                 next_ack_q;
	logic                 next_wb_q;
	logic                 rd_arm_q;
	logic                 wr_arm_q;
	logic                 drop_q;
	logic                 addr_op;
	logic                 is_read;
	assign addr_op = (op_q == pbh_pkg::PBH_OP_READ) || (op_q == pbh_pkg::PBH_OP_READ_ACK)
		|| (op_q == pbh_pkg::PBH_OP_WRITE) || (op_q == pbh_pkg::PBH_OP_WRITE_ACK);
	assign is_read = (op_q == pbh_pkg::PBH_OP_READ) || (op_q == pbh_pkg::PBH_OP_READ_ACK);
	always_ff @(posedge CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			OP_READY    <= 1'b1;
			OP_DONE     <= 1'b0;
			op_q        <= pbh_pkg::PBH_OP_READ;
			byte_q      <= 1'b0;
			addr_q      <= '0;
			wdata_q     <= '0;
			areg_q      <= '0;
			hi_q        <= 1'b0;
			addr_next_q <= 1'b0;
			next_rd_q   <= 1'b0;
			next_ack_q  <= 1'b0;
			next_wb_q   <= 1'b0;
			drop_q      <= 1'b0;
			STORE_STB   <= 1'b0;
			STORE_REG   <= '0;
			STORE_DATA  <= '0;
		end else begin
			OP_DONE   <= 1'b0;
			STORE_STB <= 1'b0;
			if (end_ph1) begin
				drop_q <= 1'b0;
			end
			if (end_ph4) begin
				addr_next_q <= 1'b0;
			end
			if (OP_READY && OP_VALID) begin
				OP_READY <= 1'b0;
				op_q     <= OP_CODE;
				byte_q   <= OP_BYTE;
				addr_q   <= OP_ADDR;
				wdata_q  <= OP_WDATA;
				areg_q   <= OP_AREG;
				hi_q     <= 1'b0;
			end else if (!OP_READY && end_ph3) begin
				if (addr_op) begin
					if (!reply_in && !busy) begin
						OP_READY    <= 1'b1;
						OP_DONE     <= 1'b1;
						addr_next_q <= 1'b1;
						next_rd_q   <= is_read;
						next_ack_q  <= (op_q == pbh_pkg::PBH_OP_READ_ACK)
							|| (op_q == pbh_pkg::PBH_OP_WRITE_ACK);
						next_wb_q   <= !is_read && byte_q;
					end
				end else if (reply_in) begin
					if (op_q == pbh_pkg::PBH_OP_INPUT_WORD && !hi_q) begin
						hi_q       <= 1'b1;
						STORE_STB  <= 1'b1;
						STORE_REG  <= areg_q;
						STORE_DATA <= DAL_I[`PBH_BYTE_W-1:0];
					end else begin
						OP_READY <= 1'b1;
						OP_DONE  <= 1'b1;
						drop_q   <= 1'b1;
						if (op_q == pbh_pkg::PBH_OP_INPUT_WORD) begin
							STORE_STB  <= 1'b1;
							STORE_REG  <= {areg_q[REG_W-1:1], !areg_q[0]};
							STORE_DATA <= DAL_I[DAL_W-1:`PBH_BYTE_W];
						end
					end
				end
			end
		end
	end
	// ****************************************
	// control chip request lines
	// ****************************************
	always_ff @(posedge CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			addr_cyc_q <= 1'b0;
			rd_arm_q   <= 1'b0;
			wr_arm_q   <= 1'b0;
			rd_xfer_q  <= 1'b0;
		end else if (end_ph4) begin
			addr_cyc_q <= addr_next_q;
			if (addr_next_q) begin
				rd_xfer_q <= next_rd_q;
			end
			if (addr_cyc_q) begin
				rd_arm_q <= rd_xfer_q;
				wr_arm_q <= !rd_xfer_q;
			end
		end else if (end_ph1 && drop_q) begin
			rd_arm_q  <= 1'b0;
			wr_arm_q  <= 1'b0;
		end
	end
	always_ff @(posedge CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			sync_req_q <= 1'b0;
			iack_req_q <= 1'b0;
		end else if (end_ph1 && drop_q) begin
			sync_req_q <= 1'b0;
			iack_req_q <= 1'b0;
		end else if (end_ph1 && addr_cyc_q) begin
			sync_req_q <= 1'b1;
			iack_req_q <= next_ack_q;
		end
	end
	always_ff @(posedge CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			BUS_WRITE_BYTE_N <= 1'b1;
		end else if (end_ph4) begin
			BUS_WRITE_BYTE_N <= !(addr_next_q && next_wb_q);
		end
	end
	always_ff @(posedge CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			in_req_q           <= 1'b0;
			BUS_INPUT_STROBE_N <= 1'b1;
		end else if (end_ph1 && drop_q) begin
			in_req_q           <= 1'b0;
			BUS_INPUT_STROBE_N <= 1'b1;
		end else if (end_ph1 && rd_arm_q) begin
			in_req_q           <= 1'b1;
			BUS_INPUT_STROBE_N <= 1'b0;
		end
	end
	always_ff @(posedge CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			out_req_q <= 1'b0;
		end else if (end_ph1 && drop_q) begin
			out_req_q <= 1'b0;
		end else if (end_ph4 && (wr_arm_q || (addr_cyc_q && !rd_xfer_q)) && !OP_READY
			&& op_q == pbh_pkg::PBH_OP_OUTPUT_WORD) begin
			out_req_q <= 1'b1;
		end
	end
	// ****************************************
	// shared address and data lines
	// ****************************************
	always_ff @(posedge CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			DAL_O  <= '0;
			DAL_OE <= 1'b0;
		end else if (end_ph4 && addr_next_q) begin
			DAL_O  <= addr_q;
			DAL_OE <= 1'b1;
		end else if (out_req_q) begin
			DAL_O  <= wdata_q;
			DAL_OE <= 1'b1;
		end else if (end_ph4 || (end_ph1 && drop_q)) begin
			DAL_OE <= 1'b0;
		end
	end
	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!rst_n_q);
	a_sync_req_ph2: assert property ($rose(sync_req_q) |-> $past(end_ph1))
		else $error("sync request rose outside phase two start");
	a_sync_ph3end: assert property ($rose(sync_ff_q) |-> $past(end_ph3) && $past(sync_req_q))
		else $error("bus sync set without phase three end");
	a_iack_block: assert property ($past(iack_req_q && end_ph3) |-> BUS_SYNC_N)
		else $error("bus sync shown during acknowledge");
	a_sync_lock: assert property (reply_ff_q && sync_ff_q && !iack_req_q |=> sync_ff_q)
		else $error("sync flip-flop left set state while reply set");
	a_wb_addr: assert property (!BUS_WRITE_BYTE_N |-> addr_cyc_q)
		else $error("write byte outside address microcycle");
	a_din_ph2: assert property ($fell(BUS_INPUT_STROBE_N) |-> $past(end_ph1 && rd_arm_q))
		else $error("input strobe not at phase two start");
	a_dout_cond: assert property ($rose(dout_ff_q) |->
		$past(end_ph2 && out_req_q && !reply_ff_q && sync_req_q))
		else $error("output strobe set without its conditions");
	a_dout_cancel: assert property (reply_ff_q |-> BUS_OUTPUT_STROBE_N)
		else $error("output strobe still active with reply set");
	a_reply_ph1: assert property (reply_ff_q != $past(reply_ff_q) |-> $past(end_ph4))
		else $error("reply flip-flop changed outside phase one");
	a_reply_gate: assert property (REPLY_OUT |-> $past(sync_ff_q))
		else $error("reply forwarded without bus sync");
	a_busy_follow: assert property (##1 BUSY_OUT == $past(reply_ff_q))
		else $error("busy does not follow reply flip-flop");
	c_input_done: cover property (STORE_STB && hi_q && OP_DONE);
	c_output_done: cover property (!BUS_OUTPUT_STROBE_N ##[1:200] OP_DONE);
	c_ack_read: cover property (iack_req_q && in_req_q);
	c_busy_wait: cover property (busy && end_ph3 && !OP_READY && addr_op);
endmodule

// >>> tb/pbh_slave.sv
// slave model answering bus strobes
`timescale 1ns/1ns
module pbh_slave (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        in_stb_n,
	input  wire logic        out_stb_n,
	input  wire logic [15:0] dal_o,
	input  wire logic [15:0] rd_data,
	input  wire logic [2:0]  dly,
	output logic             reply_n,
	output logic [15:0]      dal_i,
	output logic [15:0]      wr_data
);
	logic [2:0] cnt_q;
	logic       drive_q;
	// ****
	// strobe answer
	// ****
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reply_n <= 1'b1;
			drive_q <= 1'b0;
			cnt_q   <= 3'h0;
			wr_data <= 16'h0000;
		end else if (!in_stb_n || !out_stb_n) begin
			if (cnt_q != dly) begin
				cnt_q <= cnt_q + 3'h1;
			end else begin
				reply_n <= 1'b0;
				drive_q <= !in_stb_n;
				if (!out_stb_n) begin
					wr_data <= dal_o;
				end
			end
		end else begin
			reply_n <= 1'b1;
			drive_q <= 1'b0;
			cnt_q   <= 3'h0;
		end
	end
	// released lines show the inverse
	assign dal_i = drive_q ? rd_data : ~rd_data;
endmodule

// >>> tb/tb_top.sv
// bench of the bus handshake interface
`timescale 1ns/1ns
module tb_top;
	logic                CLK, RSTN, OP_VALID, OP_BYTE, OP_READY, OP_DONE, STORE_STB;
	pbh_pkg::pbh_op_type OP_CODE;
	logic [15:0]         OP_ADDR, OP_WDATA, DAL_I, DAL_O, rd_data, wr_data, addr_seen;
	logic [3:0]          OP_AREG, STORE_REG;
	logic [7:0]          STORE_DATA;
	logic                REPLY_OUT, BUSY_OUT, BUS_SYNC_N, BUS_WRITE_BYTE_N, DAL_OE;
	logic                BUS_INPUT_STROBE_N, BUS_OUTPUT_STROBE_N, BUS_REPLY_N;
	logic [2:0]          dly;
	logic [11:0]         stq[$];
	logic                sync_prev = 1'b1;
	logic                wb_seen, ack_mode, ack_sync;
	int                  failures, cmp_count, seed, i;
	pbh_bridge uut (.CLK(CLK), .RSTN(RSTN), .OP_VALID(OP_VALID), .OP_CODE(OP_CODE),
		.OP_BYTE(OP_BYTE), .OP_ADDR(OP_ADDR), .OP_WDATA(OP_WDATA), .OP_AREG(OP_AREG),
		.OP_READY(OP_READY), .OP_DONE(OP_DONE), .STORE_STB(STORE_STB), .STORE_REG(STORE_REG),
		.STORE_DATA(STORE_DATA), .REPLY_OUT(REPLY_OUT), .BUSY_OUT(BUSY_OUT),
		.BUS_SYNC_N(BUS_SYNC_N), .BUS_WRITE_BYTE_N(BUS_WRITE_BYTE_N),
		.BUS_INPUT_STROBE_N(BUS_INPUT_STROBE_N), .BUS_OUTPUT_STROBE_N(BUS_OUTPUT_STROBE_N),
		.BUS_REPLY_N(BUS_REPLY_N), .DAL_I(DAL_I), .DAL_O(DAL_O), .DAL_OE(DAL_OE));
	pbh_slave slave (.clk(CLK), .rst_n(RSTN), .in_stb_n(BUS_INPUT_STROBE_N),
		.out_stb_n(BUS_OUTPUT_STROBE_N), .dal_o(DAL_O), .rd_data(rd_data), .dly(dly),
		.reply_n(BUS_REPLY_N), .dal_i(DAL_I), .wr_data(wr_data));
	// ****
	// tasks
	// ****
	task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	function automatic logic [15:0] exp_store(logic [3:0] r, logic [15:0] d, bit hi);
		return hi ? {4'h0, r ^ 4'h1, d[15:8]} : {4'h0, r, d[7:0]};
	endfunction
	task automatic do_op(input pbh_pkg::pbh_op_type c, input logic b, input logic [15:0] a,
		input logic [15:0] w, input logic [3:0] r);
		int n;
		@(negedge CLK);
		OP_VALID = 1'b1;
		OP_CODE = c;
		OP_BYTE = b;
		OP_ADDR = a;
		OP_WDATA = w;
		OP_AREG = r;
		for (n = 0; n < 400 && OP_READY !== 1'b1; n++) @(negedge CLK);
		@(negedge CLK);
		OP_VALID = 1'b0;
	endtask
	task automatic reset_dut();
		@(negedge CLK);
		RSTN = 1'b0;
		repeat (8) @(negedge CLK);
		RSTN = 1'b1;
		repeat (4) @(negedge CLK);
		check("ready after reset", 16'h0001, {15'h0, OP_READY});
	endtask
	task automatic xfer(input bit rd, input int dl);
		logic [15:0] a, d;
		logic [3:0]  r;
		logic        b;
		int          n;
		a = 16'($random(seed));
		d = 16'($random(seed));
		r = 4'($random(seed));
		b = rd ? 1'b0 : 1'($random(seed));
		rd_data = d;
		dly = (dl < 0) ? 3'($random(seed)) : 3'(dl);
		stq.delete();
		wb_seen = 1'b0;
		do_op(rd ? pbh_pkg::PBH_OP_READ : pbh_pkg::PBH_OP_WRITE, b, a, d, r);
		do_op(rd ? pbh_pkg::PBH_OP_INPUT_WORD : pbh_pkg::PBH_OP_OUTPUT_WORD, b, a, d, r);
		for (n = 0; n < 400 && OP_DONE !== 1'b1; n++) @(negedge CLK);
		#1;
		check("op done", 16'h0001, {15'h0, OP_DONE});
		check("busy after transfer", 16'h0001, {15'h0, BUSY_OUT});
		check("reply forwarded", 16'h0001, {15'h0, REPLY_OUT});
		check("data enable", {15'h0, !rd}, {15'h0, DAL_OE});
		check("address on bus", a, addr_seen);
		if (rd) begin
			check("store count", 16'h0002, 16'(stq.size()));
			check("low byte", exp_store(r, d, 1'b0), {4'h0, stq[0]});
			check("high byte", exp_store(r, d, 1'b1), {4'h0, stq[1]});
			check("sync held", 16'h0000, {15'h0, BUS_SYNC_N});
			repeat (5) @(negedge CLK);
			check("reply after drop", 16'h0000, {15'h0, REPLY_OUT});
			check("input strobe after drop", 16'h0001, {15'h0, BUS_INPUT_STROBE_N});
			check("sync locked", 16'h0000, {15'h0, BUS_SYNC_N});
			check("busy locked", 16'h0001, {15'h0, BUSY_OUT});
		end else begin
			check("written data", d, wr_data);
			check("data lines", d, DAL_O);
			check("write byte line", {15'h0, b}, {15'h0, wb_seen});
		end
		$display("transfer end rd=%0d dly=%0d", rd, dly);
	endtask
	task automatic ack_run(input pbh_pkg::pbh_op_type c, input pbh_pkg::pbh_op_type nx);
		int n;
		for (n = 0; n < 400 && !(BUS_SYNC_N === 1'b1 && BUSY_OUT === 1'b0); n++) @(negedge CLK);
		check("bus released", 16'h0001, {15'h0, BUS_SYNC_N});
		ack_mode = 1'b1;
		ack_sync = 1'b0;
		do_op(c, 1'b0, 16'h0040, 16'h00a5, 4'h2);
		do_op(nx, 1'b0, 16'h0040, 16'h00a5, 4'h2);
		repeat (64) @(negedge CLK);
		check("sync in acknowledge", 16'h0000, {15'h0, ack_sync});
		ack_mode = 1'b0;
		reset_dut();
		$display("acknowledge end code=%0d", c);
	endtask
	// ****
	// monitor
	// ****
	always @(negedge CLK) begin
		if (STORE_STB === 1'b1) begin
			stq.push_back({STORE_REG, STORE_DATA});
		end
		if (BUS_WRITE_BYTE_N === 1'b0) begin
			wb_seen = 1'b1;
		end
		if (sync_prev === 1'b1 && BUS_SYNC_N === 1'b0) begin
			addr_seen = DAL_O;
		end
		if (RSTN === 1'b1 && sync_prev === 1'b0 && BUS_SYNC_N === 1'b1) begin
			check("reply before sync release", 16'h0001, {15'h0, BUS_REPLY_N});
		end
		if (ack_mode && BUS_SYNC_N !== 1'b1) begin
			ack_sync = 1'b1;
		end
		sync_prev = BUS_SYNC_N;
	end
	// ****
	// clock, main sequence, watchdog
	// ****
	initial begin
		CLK = 1'b0;
		forever #25 CLK = ~CLK;
	end
	initial begin
		seed = 32'h0e47f8d6;
		RSTN = 1'b0;
		OP_VALID = 1'b0;
		OP_CODE = pbh_pkg::PBH_OP_READ;
		OP_BYTE = 1'b0;
		OP_ADDR = 16'h0000;
		OP_WDATA = 16'h0000;
		OP_AREG = 4'h0;
		rd_data = 16'h0000;
		dly = 3'h0;
		ack_mode = 1'b0;
		failures = 0;
		cmp_count = 0;
		reset_dut();
		xfer(1'b1, 0);
		xfer(1'b0, 0);
		xfer(1'b1, 7);
		xfer(1'b0, 7);
		for (i = 0; i < 12; i++) xfer(1'($random(seed)), -1);
		ack_run(pbh_pkg::PBH_OP_READ_ACK, pbh_pkg::PBH_OP_INPUT_WORD);
		ack_run(pbh_pkg::PBH_OP_WRITE_ACK, pbh_pkg::PBH_OP_OUTPUT_WORD);
		conclude();
	end
	initial begin
		#2000000;
		failures++;
		conclude();
	end
endmodule
